//--- hw/rot_bitset_core.sv
`timescale 1ns/10ps
`default_nettype none

`include "rot_bitset_consts.svh"

// Functional notes
// - Plain right rotate moves each accumulator bit down one place, bit 0 wrapping to bit 7.
// - Plain right rotate changes the accumulator only, leaving carry and all flags.
// - Rotate through carry turns accumulator and carry as a nine-bit ring to the right.
// - Rotate through carry changes only accumulator and carry, no other flag.
// - Bit set forces the carry or the addressed bit to one and changes no other flag.
// - Bit set on a port latch bit raises only that bit and the port output follows.
module rot_bitset_core
    import rot_bitset_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic             i_op_valid,
    input  wire op_t              i_op,
    input  wire logic [7:0]       i_bit_addr,
    input  wire logic             i_acc_load,
    input  wire logic [WIDTH-1:0] i_acc_load_value,
    input  wire logic             i_psw_load,
    input  wire logic [7:0]       i_psw_load_value,
    input  wire logic             i_port_load,
    input  wire logic [WIDTH-1:0] i_port_load_value,
    output logic      [WIDTH-1:0] o_acc,
    output logic      [7:0]       o_psw,
    output logic      [WIDTH-1:0] o_port,
    output logic                  o_bit_write,
    output logic      [7:0]       o_bit_write_addr,
    output logic                  o_done
);

    initial begin
        if (WIDTH != 8) begin
            $error("rot_bitset_core: WIDTH must be 8");
        end
        if (`OP_LATENCY_CYC != 1) begin
            $error("rot_bitset_core: latency must be one cycle");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] acc;
        logic [7:0]       psw;
        logic [WIDTH-1:0] port;
        logic             bit_write;
        logic [7:0]       bit_write_addr;
        logic             done;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [WIDTH-1:0] rot_value;
    logic             rot_carry;

    function automatic logic is_port_bit(input logic [7:0] addr);
        return (addr >= `PORT_BIT_BASE) && (addr < (`PORT_BIT_BASE + 8'h08));
    endfunction

    rotate_unit #(
        .WIDTH (WIDTH)
    ) u_rotate (
        .i_value         (state_reg.acc),
        .i_carry         (state_reg.psw[`PSW_CARRY_POS]),
        .i_through_carry (i_op == OP_ROTATE_RIGHT_THROUGH_CARRY),
        .o_value         (rot_value),
        .o_carry         (rot_carry)
    );

    always_comb begin
        state_next           = state_reg;
        state_next.bit_write = 1'b0;
        state_next.done      = 1'b0;
        if (i_acc_load) begin
            state_next.acc = i_acc_load_value;
        end
        if (i_psw_load) begin
            state_next.psw = i_psw_load_value;
        end
        if (i_port_load) begin
            state_next.port = i_port_load_value;
        end
        if (i_op_valid) begin
            state_next.done = 1'b1;
            case (i_op)
                OP_ROTATE_RIGHT_PLAIN: begin
                    state_next.acc = rot_value;
                    state_next.psw = state_reg.psw;
                end
                OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                    state_next.acc = rot_value;
                    state_next.psw = state_reg.psw;
                    state_next.psw[`PSW_CARRY_POS] = rot_carry;
                end
                OP_FORCE_BIT_HIGH_CARRY: begin
                    state_next.psw[`PSW_CARRY_POS] = 1'b1;
                end
                OP_FORCE_BIT_HIGH_BIT: begin
                    if (is_port_bit(i_bit_addr)) begin
                        state_next.port[i_bit_addr[2:0]] = 1'b1;
                    end else begin
                        state_next.bit_write      = 1'b1;
                        state_next.bit_write_addr = i_bit_addr;
                    end
                end
                default: begin
                    state_next.done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg.acc            <= `ACC_RESET;
            state_reg.psw            <= `PSW_RESET;
            state_reg.port           <= `PORT_RESET;
            state_reg.bit_write      <= 1'b0;
            state_reg.bit_write_addr <= 8'h00;
            state_reg.done           <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_acc            = state_reg.acc;
    assign o_psw            = state_reg.psw;
    assign o_port           = state_reg.port;
    assign o_bit_write      = state_reg.bit_write;
    assign o_bit_write_addr = state_reg.bit_write_addr;
    assign o_done           = state_reg.done;

endmodule // rot_bitset_core

`default_nettype wire

//--- hw/rotate_unit.sv
`timescale 1ns/10ps
`default_nettype none

`include "rot_bitset_consts.svh"

module rotate_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] i_value,
    input  wire logic             i_carry,
    input  wire logic             i_through_carry,
    output logic      [WIDTH-1:0] o_value,
    output logic                  o_carry
);

    initial begin
        if (WIDTH < 2) begin
            $error("rotate_unit: WIDTH must be at least 2");
        end
    end

    always_comb begin
        if (i_through_carry) begin
            o_value = {i_carry, i_value[WIDTH-1:1]};
            o_carry = i_value[0];
        end else begin
            o_value = {i_value[0], i_value[WIDTH-1:1]};
            o_carry = i_carry;
        end
    end

endmodule // rotate_unit

`default_nettype wire

//--- inc/rot_bitset_consts.svh
`ifndef ROT_BITSET_CONSTS_SVH
`define ROT_BITSET_CONSTS_SVH

// Reset values
`define ACC_RESET        8'h00
`define CARRY_RESET      1'b0
`define PSW_RESET        8'h00
`define PORT_RESET       8'hFF
// Carry position inside the status byte
`define PSW_CARRY_POS    7
// Bit-address space: the eight addresses starting at this one hit the output port latch
`define PORT_BIT_BASE    8'h90
// Result latency of every operation, in clock cycles
`define OP_LATENCY_CYC   1

`endif

//--- inc/rot_bitset_pkg.sv
package rot_bitset_pkg;

    typedef enum logic [2:0] {
        OP_NONE                       = 3'h0,
        OP_ROTATE_RIGHT_PLAIN         = 3'h1,
        OP_ROTATE_RIGHT_THROUGH_CARRY = 3'h3,
        OP_FORCE_BIT_HIGH_CARRY       = 3'h2,
        OP_FORCE_BIT_HIGH_BIT         = 3'h6
    } op_t;

endpackage

//--- sim/rot_bitset_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rot_bitset_core_checker
    import rot_bitset_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_op_valid,
    input wire op_t        i_op,
    input wire logic [7:0] i_bit_addr,
    input wire logic       i_psw_load,
    input wire logic       i_port_load,
    input wire logic [7:0] o_acc,
    input wire logic [7:0] o_psw,
    input wire logic [7:0] o_port,
    input wire logic       o_bit_write,
    input wire logic [7:0] o_bit_write_addr,
    input wire logic       o_done
);
    logic rr, rc, sc, sb;
    assign rr = i_op_valid && i_op == OP_ROTATE_RIGHT_PLAIN;
    assign rc = i_op_valid && i_op == OP_ROTATE_RIGHT_THROUGH_CARRY;
    assign sc = i_op_valid && i_op == OP_FORCE_BIT_HIGH_CARRY;
    assign sb = i_op_valid && i_op == OP_FORCE_BIT_HIGH_BIT;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_rr; rr |=> o_acc == {$past(o_acc[0]), $past(o_acc[7:1])}; endproperty
    a_rr: assert property (p_rr) else $error("rotate acc wrong");
    property p_rr_f; rr && !i_psw_load |=> $stable(o_psw); endproperty
    a_rr_f: assert property (p_rr_f) else $error("rotate flags moved");
    property p_rc; rc |=> {o_acc, o_psw[7]} == {$past(o_psw[7]), $past(o_acc)}; endproperty
    a_rc: assert property (p_rc) else $error("ring rotate wrong");
    property p_rc_f; rc && !i_psw_load |=> $stable(o_psw[6:0]); endproperty
    a_rc_f: assert property (p_rc_f) else $error("ring flags moved");
    property p_sc; sc && !i_psw_load |=> o_psw == ($past(o_psw) | 8'h80); endproperty
    a_sc: assert property (p_sc) else $error("carry set wrong");
    property p_sb;
        sb && i_bit_addr[7:3] == 5'h12 && !i_port_load
            |=> o_port == ($past(o_port) | (8'h01 << $past(i_bit_addr[2:0])));
    endproperty
    a_sb: assert property (p_sb) else $error("port bit set wrong");
    property p_bw;
        sb && i_bit_addr[7:3] != 5'h12
            |=> o_bit_write && o_bit_write_addr == $past(i_bit_addr);
    endproperty
    a_bw: assert property (p_bw) else $error("bit write wrong");
    property p_done; rr || rc || sc || sb |=> o_done; endproperty
    a_done: assert property (p_done) else $error("done missing");
endmodule // rot_bitset_core_checker
bind rot_bitset_core rot_bitset_core_checker i_chk (.*);
`default_nettype wire

//--- sim/rot_bitset_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rot_bitset_core_tb;
    import rot_bitset_pkg::*;
    logic i_clock = 0, i_rst_n = 0, i_op_valid = 0, i_acc_load = 0, i_psw_load = 0;
    logic i_port_load = 0, o_bit_write, o_done, r;
    op_t  i_op = OP_NONE;
    logic [7:0] i_bit_addr = 8'h00, i_acc_load_value = 8'h00, i_psw_load_value = 8'h00;
    logic [7:0] i_port_load_value = 8'h00, o_acc, o_psw, o_port, o_bit_write_addr, a, p, q, b;
    logic [32:0] notes[$];
    logic [7:0] w = 8'h00;
    logic wr;
    int miscompares = 0, comparisons = 0;
    op_t ops[4] = '{OP_ROTATE_RIGHT_PLAIN, OP_ROTATE_RIGHT_THROUGH_CARRY,
                    OP_FORCE_BIT_HIGH_CARRY, OP_FORCE_BIT_HIGH_BIT};
    always #10 i_clock = ~i_clock;
    rot_bitset_core i_dut (.*);
    task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] s);
        comparisons++;
        if (e !== s) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(negedge i_clock) if (o_done === 1'b1)
        cmp("acc psw port bitwrite", notes.size() ? notes.pop_front() : 33'hX,
            {o_acc, o_psw, o_port, o_bit_write, o_bit_write_addr});
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(39));
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge i_clock);
            {a, p, q, b} = $urandom;
            b = {(b[3] ? 5'h12 : {1'b0, b[7:4]}), b[2:0]};
            i_op_valid <= 1'b0;
            {i_acc_load, i_psw_load, i_port_load} <= 3'h7;
            {i_acc_load_value, i_psw_load_value, i_port_load_value} <= {a, p, q};
            @(posedge i_clock);
            {i_acc_load, i_psw_load, i_port_load} <= 3'h0;
            r = (n % 7 == 6);
            i_op_valid <= 1'b1;
            i_op <= r ? OP_NONE : ops[n % 4];
            i_bit_addr <= b;
            if (!r) begin
                wr = 1'b0;
                case (ops[n % 4])
                    OP_ROTATE_RIGHT_PLAIN: a = {a[0], a[7:1]};
                    OP_ROTATE_RIGHT_THROUGH_CARRY: {a, p[7]} = {p[7], a};
                    OP_FORCE_BIT_HIGH_CARRY: p[7] = 1'b1;
                    default: if (b[7:3] == 5'h12) q[b[2:0]] = 1'b1;
                             else begin
                                 wr = 1'b1;
                                 w = b;
                             end
                endcase
                notes.push_back({a, p, q, wr, w});
            end
        end
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        repeat (3) @(posedge i_clock);
        cmp("pending results", 33'h0, 33'(notes.size()));
        end_sim();
    end
endmodule // rot_bitset_core_tb
`default_nettype wire
